/* File: hw/cmoc_pkg.sv */
// What this block does
// - high impedance bit set enters low quiescent mode; cleared returns to normal
// - in high impedance with bus above lockout, regulator stays on, system on battery
// - restore bit returns all registers to defaults except the input voltage threshold
// - restore bit clears itself once the restore has finished
// - re-measure bit disables the converter for the threshold measurement
// - measurement done clears the re-measure bit and restarts the converter unless the high impedance bit is set
// - reverse supply runs only while its bit and the external pin are both high
// - optimizer bit one runs the optimizer, zero keeps it off
// - lower bit 1 opens the battery switch during high impedance mode
// - lower bit 0 selects the power monitor source in every mode, reverse supply or not
// - mode register at 35h/34h resets to zero, upper 2-0 and lower 7-2 reserved
// - alert option register at 37h/36h resets to 4a54h with its field layout
package cmoc_pkg;

  localparam logic [7:0]  MODE_LO_ADDR  = 8'h34;
  localparam logic [7:0]  MODE_HI_ADDR  = 8'h35;
  localparam logic [7:0]  ALERT_LO_ADDR = 8'h36;
  localparam logic [7:0]  ALERT_HI_ADDR = 8'h37;

  localparam int          HIZ_BIT       = 7;
  localparam int          RESTORE_BIT   = 6;
  localparam int          REMEASURE_BIT = 5;

  localparam logic [15:0] MODE_RESET    = 16'h0000;
  localparam logic [15:0] ALERT_RESET   = 16'h4a54;
  localparam logic [7:0]  MODE_HI_MASK  = 8'hf8;
  localparam logic [7:0]  MODE_LO_MASK  = 8'h03;
  localparam logic [7:0]  ALERT_HI_MASK = 8'hfe;
  localparam logic [7:0]  ALERT_LO_MASK = 8'hfe;
  localparam logic [7:0]  UNMAPPED_DATA = 8'h00;

  localparam int          CLK_PERIOD_NS   = 5;
  localparam int          RESTORE_TIME_NS = 20;
  localparam int          RESTORE_CYCLES  =
    (RESTORE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RESTORE_CNT_W   = 3;

  localparam int          SYNC_STAGES     = 3;

  typedef struct packed {
    logic       high_impedance_enable;
    logic       restore_defaults_command;
    logic       threshold_remeasure_command;
    logic       reverse_supply_enable;
    logic       input_optimizer_enable;
    logic [2:0] reserved_hi;
    logic [5:0] reserved_lo;
    logic       battery_switch_open_idle;
    logic       power_monitor_source_select;
  } cmoc_mode_type;

  typedef struct packed {
    logic [4:0] overcurrent_alert_threshold;
    logic [1:0] critical_current_deglitch;
    logic       reserved_hi;
    logic [1:0] system_voltage_alert_threshold;
    logic       alert_pulse_extension_enable;
    logic [1:0] alert_pulse_width;
    logic       alert_pulse_clear;
    logic       nominal_current_deglitch;
    logic       reserved_lo;
  } cmoc_alert_type;

  typedef struct packed {
    logic hiz_mode;
    logic regulator_on;
    logic system_from_battery;
    logic battery_switch_open;
    logic converter_disable;
    logic reverse_supply_active;
    logic optimizer_run;
    logic monitor_select;
    logic restore_pulse;
  } cmoc_out_type;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_RESTORE
  } cmoc_cmd_state_type;

endpackage

/* File: hw/cmoc_sync.sv */
module cmoc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } cmoc_sync_state_type;

  cmoc_sync_state_type st_ff;
  cmoc_sync_state_type nxt_st;

  if (W < 1) begin : g_chk
    $error("cmoc_sync: width must be at least one");
  end

  // s1 feeds only s2; a change is taken once s2 and s3 agree
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < W; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.q[i] = st_ff.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.q;

endmodule // cmoc_sync

/* File: hw/cmoc_top.sv */
module cmoc_top #(
  parameter int RESTORE_LEN = cmoc_pkg::RESTORE_CYCLES
) (
  input  wire logic       MCLK,
  input  wire logic       RESETN,
  input  wire logic       CE,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic       REG_WR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  input  wire logic       REVERSE_PIN,
  input  wire logic       VBUS_ABOVE_UVLO,
  input  wire logic       MEASURE_DONE,
  output logic            HIZ_MODE,
  output logic            REGULATOR_ON,
  output logic            SYSTEM_FROM_BATTERY,
  output logic            BATTERY_SWITCH_OPEN,
  output logic            CONVERTER_DISABLE,
  output logic            REVERSE_SUPPLY_ACTIVE,
  output logic            OPTIMIZER_RUN,
  output logic            POWER_MONITOR_SELECT,
  output logic            RESTORE_PULSE,
  output logic     [15:0] ALERT_OPTION
);

  typedef struct packed {
    cmoc_pkg::cmoc_mode_type                    mode;
    cmoc_pkg::cmoc_alert_type                   alert;
    cmoc_pkg::cmoc_cmd_state_type               cmd;
    logic [cmoc_pkg::RESTORE_CNT_W-1:0]         restore_cnt;
    logic [7:0]                                 rdata;
    cmoc_pkg::cmoc_out_type                     out;
  } cmoc_state_type;

  localparam logic [cmoc_pkg::RESTORE_CNT_W-1:0] RESTORE_LOAD =
    cmoc_pkg::RESTORE_CNT_W'(RESTORE_LEN - 1);

  if (RESTORE_LEN < 1 || RESTORE_LEN > (1 << cmoc_pkg::RESTORE_CNT_W)) begin : g_chk
    $error("cmoc_top: restore length out of range");
  end

  logic           rst_meta_ff;
  logic           rst_n_ff;
  cmoc_state_type st_ff;
  cmoc_state_type nxt_st;
  logic [1:0]     pins_sync;
  logic           rev_pin_ok;
  logic           vbus_ok;

  // reset is released on the clock so no flop leaves reset mid-edge
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  cmoc_sync #(
    .W (2)
  ) u_pin_sync (
    .clk   (MCLK),
    .rst_n (rst_n_ff),
    .ce    (CE),
    .d     ({REVERSE_PIN, VBUS_ABOVE_UVLO}),
    .q     (pins_sync)
  );

  assign rev_pin_ok = pins_sync[1];
  assign vbus_ok    = pins_sync[0];

  always_comb begin
    logic [7:0] wd_hi;
    logic [7:0] wd_lo;
    logic       busy_restore;
    nxt_st       = st_ff;
    wd_hi        = REG_WDATA & cmoc_pkg::MODE_HI_MASK;
    wd_lo        = REG_WDATA & cmoc_pkg::MODE_LO_MASK;
    busy_restore = (st_ff.cmd == cmoc_pkg::ST_RESTORE);

    case (st_ff.cmd)
      cmoc_pkg::ST_IDLE: begin
        // measurement finishing ends the re-measure command
        if (st_ff.mode.threshold_remeasure_command && MEASURE_DONE) begin
          nxt_st.mode.threshold_remeasure_command = 1'b0;
        end
        if (REG_WR) begin
          case (REG_ADDR)
            cmoc_pkg::MODE_HI_ADDR: begin
              nxt_st.mode.high_impedance_enable = wd_hi[cmoc_pkg::HIZ_BIT];
              nxt_st.mode.reverse_supply_enable  = wd_hi[4];
              nxt_st.mode.input_optimizer_enable = wd_hi[3];
              // a one while already measuring changes nothing
              if (wd_hi[cmoc_pkg::REMEASURE_BIT] &&
                  !st_ff.mode.threshold_remeasure_command) begin
                nxt_st.mode.threshold_remeasure_command = 1'b1;
              end
              if (wd_hi[cmoc_pkg::RESTORE_BIT]) begin
                nxt_st.mode.restore_defaults_command = 1'b1;
                nxt_st.cmd                           = cmoc_pkg::ST_RESTORE;
                nxt_st.restore_cnt                   = RESTORE_LOAD;
              end
            end
            cmoc_pkg::MODE_LO_ADDR: begin
              nxt_st.mode.battery_switch_open_idle    = wd_lo[1];
              nxt_st.mode.power_monitor_source_select = wd_lo[0];
            end
            cmoc_pkg::ALERT_HI_ADDR: begin
              nxt_st.alert[15:8] = REG_WDATA & cmoc_pkg::ALERT_HI_MASK;
            end
            cmoc_pkg::ALERT_LO_ADDR: begin
              nxt_st.alert[7:0] = REG_WDATA & cmoc_pkg::ALERT_LO_MASK;
            end
            default: begin
            end
          endcase
        end
      end
      cmoc_pkg::ST_RESTORE: begin
        // writes are dropped here: the restore would overwrite them anyway
        if (st_ff.restore_cnt == '0) begin
          nxt_st.mode = cmoc_pkg::MODE_RESET;
          nxt_st.alert = cmoc_pkg::ALERT_RESET;
          nxt_st.cmd  = cmoc_pkg::ST_IDLE;
        end else begin
          nxt_st.restore_cnt = st_ff.restore_cnt - 1'b1;
        end
      end
      default: begin
        nxt_st.cmd = cmoc_pkg::ST_IDLE;
      end
    endcase

    if (REG_RD) begin
      case (REG_ADDR)
        cmoc_pkg::MODE_HI_ADDR:  nxt_st.rdata = st_ff.mode[15:8];
        cmoc_pkg::MODE_LO_ADDR:  nxt_st.rdata = st_ff.mode[7:0];
        cmoc_pkg::ALERT_HI_ADDR: nxt_st.rdata = st_ff.alert[15:8];
        cmoc_pkg::ALERT_LO_ADDR: nxt_st.rdata = st_ff.alert[7:0];
        default:                 nxt_st.rdata = cmoc_pkg::UNMAPPED_DATA;
      endcase
    end

    // outputs follow the next mode so they line up with the stored bits
    nxt_st.out.hiz_mode            = nxt_st.mode.high_impedance_enable;
    // regulator drops only in high impedance with the bus below lockout
    nxt_st.out.regulator_on        = !nxt_st.mode.high_impedance_enable || vbus_ok;
    nxt_st.out.system_from_battery = nxt_st.mode.high_impedance_enable;
    nxt_st.out.battery_switch_open = nxt_st.mode.high_impedance_enable &&
                                     nxt_st.mode.battery_switch_open_idle;
    nxt_st.out.converter_disable   = nxt_st.mode.high_impedance_enable ||
                                     nxt_st.mode.threshold_remeasure_command;
    nxt_st.out.reverse_supply_active = nxt_st.mode.reverse_supply_enable && rev_pin_ok;
    nxt_st.out.optimizer_run       = nxt_st.mode.input_optimizer_enable;
    nxt_st.out.monitor_select      = nxt_st.mode.power_monitor_source_select;
    nxt_st.out.restore_pulse       = (nxt_st.cmd == cmoc_pkg::ST_RESTORE) && !busy_restore;
  end

  always_ff @(posedge MCLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      st_ff       <= '0;
      st_ff.mode  <= cmoc_pkg::MODE_RESET;
      st_ff.alert <= cmoc_pkg::ALERT_RESET;
      st_ff.cmd   <= cmoc_pkg::ST_IDLE;
      st_ff.out.regulator_on <= 1'b1;
    end else if (CE) begin
      st_ff <= nxt_st;
    end
  end

  assign REG_RDATA             = st_ff.rdata;
  assign HIZ_MODE              = st_ff.out.hiz_mode;
  assign REGULATOR_ON          = st_ff.out.regulator_on;
  assign SYSTEM_FROM_BATTERY   = st_ff.out.system_from_battery;
  assign BATTERY_SWITCH_OPEN   = st_ff.out.battery_switch_open;
  assign CONVERTER_DISABLE     = st_ff.out.converter_disable;
  assign REVERSE_SUPPLY_ACTIVE = st_ff.out.reverse_supply_active;
  assign OPTIMIZER_RUN         = st_ff.out.optimizer_run;
  assign POWER_MONITOR_SELECT  = st_ff.out.monitor_select;
  assign RESTORE_PULSE         = st_ff.out.restore_pulse;
  assign ALERT_OPTION          = st_ff.alert;

  AST_HIZ_FOLLOWS_BIT: assert property (
    @(posedge MCLK) disable iff (!rst_n_ff)
    (CE && st_ff.cmd == cmoc_pkg::ST_IDLE && REG_WR && REG_ADDR == cmoc_pkg::MODE_HI_ADDR)
    |=> HIZ_MODE == $past(REG_WDATA[cmoc_pkg::HIZ_BIT])
  ) else $error("high impedance output does not follow the written bit");

  AST_HIZ_SUPPLY: assert property (
    @(posedge MCLK) disable iff (!rst_n_ff)
    (CE && st_ff.mode.high_impedance_enable && vbus_ok && !REG_WR &&
     st_ff.cmd == cmoc_pkg::ST_IDLE)
    |=> REGULATOR_ON && SYSTEM_FROM_BATTERY
  ) else $error("regulator or battery supply lost in high impedance");

  AST_RESTORE_DONE: assert property (
    @(posedge MCLK) disable iff (!rst_n_ff)
    (CE && st_ff.cmd == cmoc_pkg::ST_RESTORE && st_ff.restore_cnt == '0)
    |=> st_ff.mode == cmoc_pkg::MODE_RESET && st_ff.alert == cmoc_pkg::ALERT_RESET
  ) else $error("restore did not reload defaults");

  // a frozen clock enable stretches the restore, so such attempts are dropped
  AST_RESTORE_SELF_CLEAR: assert property (
    @(posedge MCLK) disable iff (!rst_n_ff || !CE)
    (st_ff.cmd == cmoc_pkg::ST_IDLE && REG_WR &&
     REG_ADDR == cmoc_pkg::MODE_HI_ADDR && REG_WDATA[cmoc_pkg::RESTORE_BIT])
    |=> st_ff.mode.restore_defaults_command ##[1:8] !st_ff.mode.restore_defaults_command
  ) else $error("restore bit did not clear itself");

  AST_RESTORE_READS_ONE: assert property (
    @(posedge MCLK) disable iff (!rst_n_ff)
    (st_ff.cmd == cmoc_pkg::ST_RESTORE) |-> st_ff.mode.restore_defaults_command
  ) else $error("restore bit reads zero while busy");

  AST_REMEASURE_DISABLES: assert property (
    @(posedge MCLK) disable iff (!rst_n_ff)
    st_ff.mode.threshold_remeasure_command |-> CONVERTER_DISABLE
  ) else $error("converter running during threshold measurement");

  AST_REMEASURE_END: assert property (
    @(posedge MCLK) disable iff (!rst_n_ff)
    (CE && st_ff.cmd == cmoc_pkg::ST_IDLE && st_ff.mode.threshold_remeasure_command &&
     MEASURE_DONE)
    |=> !st_ff.mode.threshold_remeasure_command
  ) else $error("re-measure bit not cleared after measurement");

  AST_REVERSE_NEEDS_PIN: assert property (
    @(posedge MCLK) disable iff (!rst_n_ff)
    (REVERSE_SUPPLY_ACTIVE && $past(CE)) |-> st_ff.mode.reverse_supply_enable &&
                                            $past(rev_pin_ok)
  ) else $error("reverse supply without bit and pin");

  AST_OPTIMIZER: assert property (
    @(posedge MCLK) disable iff (!rst_n_ff)
    (CE && st_ff.cmd == cmoc_pkg::ST_IDLE && REG_WR && REG_ADDR == cmoc_pkg::MODE_HI_ADDR)
    |=> OPTIMIZER_RUN == $past(REG_WDATA[3])
  ) else $error("optimizer state does not follow the written bit");

  AST_SWITCH_OPEN: assert property (
    @(posedge MCLK) disable iff (!rst_n_ff)
    BATTERY_SWITCH_OPEN == (st_ff.mode.high_impedance_enable &&
                            st_ff.mode.battery_switch_open_idle)
  ) else $error("battery switch state wrong");

  AST_MONITOR_SELECT: assert property (
    @(posedge MCLK) disable iff (!rst_n_ff)
    (CE && st_ff.cmd == cmoc_pkg::ST_IDLE && REG_WR && REG_ADDR == cmoc_pkg::MODE_LO_ADDR)
    |=> POWER_MONITOR_SELECT == $past(REG_WDATA[0])
  ) else $error("power monitor source does not follow the written bit");

  AST_MODE_READ: assert property (
    @(posedge MCLK) disable iff (!rst_n_ff)
    (CE && REG_RD && REG_ADDR == cmoc_pkg::MODE_HI_ADDR)
    |=> REG_RDATA == $past(st_ff.mode[15:8]) && REG_RDATA[2:0] == 3'h0
  ) else $error("mode upper byte read back wrong");

  AST_ALERT_RESET: assert property (
    @(posedge MCLK)
    $rose(rst_n_ff) |-> st_ff.alert == cmoc_pkg::ALERT_RESET
  ) else $error("alert option register not at reset value");

endmodule // cmoc_top

/* File: test/cmoc_host_model.sv */
// byte-strobe host that speaks for the serial byte engine
module cmoc_host_model (
  input  wire logic       clk,
  output logic      [7:0] addr,
  output logic            wr,
  output logic      [7:0] wdata,
  output logic            rd,
  input  wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    addr  = 8'h00;
    wr    = 1'b0;
    wdata = 8'h00;
    rd    = 1'b0;
  end

  // idle lines show the inverse so a stale value is never mistaken for a live one
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    @(posedge clk);
    #1;
    wr    = 1'b0;
    addr  = ~a;
    wdata = ~d;
  endtask

  task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    rd   = 1'b1;
    @(posedge clk);
    #1;
    d    = rdata;
    rd   = 1'b0;
    addr = ~a;
  endtask
endmodule // cmoc_host_model

/* File: test/cmoc_top_tb.sv */
module cmoc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // long restore window so accesses land well inside it
  localparam int RLEN = 8;

  logic        mclk;
  logic        resetn;
  logic        ce;
  logic        reverse_pin;
  logic        vbus_ok;
  logic        measure_done;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic [7:0]  reg_wdata;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [15:0] alert_option;
  logic [8:0]  outs;
  int          err_count;
  int          samples_checked;

  cmoc_top #(.RESTORE_LEN(RLEN)) DUT (
    .MCLK                  (mclk),
    .RESETN                (resetn),
    .CE                    (ce),
    .REG_ADDR              (reg_addr),
    .REG_WR                (reg_wr),
    .REG_WDATA             (reg_wdata),
    .REG_RD                (reg_rd),
    .REG_RDATA             (reg_rdata),
    .REVERSE_PIN           (reverse_pin),
    .VBUS_ABOVE_UVLO       (vbus_ok),
    .MEASURE_DONE          (measure_done),
    .HIZ_MODE              (outs[8]),
    .REGULATOR_ON          (outs[7]),
    .SYSTEM_FROM_BATTERY   (outs[6]),
    .BATTERY_SWITCH_OPEN   (outs[5]),
    .CONVERTER_DISABLE     (outs[4]),
    .REVERSE_SUPPLY_ACTIVE (outs[3]),
    .OPTIMIZER_RUN         (outs[2]),
    .POWER_MONITOR_SELECT  (outs[1]),
    .RESTORE_PULSE         (outs[0]),
    .ALERT_OPTION          (alert_option)
  );

  cmoc_host_model host (
    .clk   (mclk),
    .addr  (reg_addr),
    .wr    (reg_wr),
    .wdata (reg_wdata),
    .rd    (reg_rd),
    .rdata (reg_rdata)
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.read_byte(a, d);
    check(16'(d), 16'(exp));
  endtask

  // pin synchroniser needs about four edges; eight leaves margin
  task automatic settle();
    repeat (8) @(posedge mclk);
    #1;
  endtask

  task automatic reset_values();
    check(16'(outs), 16'h0080);
    check(alert_option, cmoc_pkg::ALERT_RESET);
    rd_chk(8'h34, 8'h00);
    rd_chk(8'h35, 8'h00);
    rd_chk(8'h36, 8'h54);
    rd_chk(8'h37, 8'h4a);
  endtask

  task automatic mode_fields();
    host.write_byte(8'h35, 8'h1f);
    rd_chk(8'h35, 8'h18);
    host.write_byte(8'h34, 8'hff);
    rd_chk(8'h34, 8'h03);
    check(16'(outs), 16'h0086);
    host.write_byte(8'h35, 8'h00);
    host.write_byte(8'h34, 8'h00);
    check(16'(outs), 16'h0080);
    host.write_byte(8'h40, 8'hff);
    rd_chk(8'h40, 8'h00);
  endtask

  task automatic alert_fields();
    host.write_byte(8'h37, 8'hff);
    host.write_byte(8'h36, 8'hff);
    rd_chk(8'h37, 8'hfe);
    rd_chk(8'h36, 8'hfe);
    check(alert_option, 16'hfefe);
  endtask

  task automatic hiz_mode();
    host.write_byte(8'h34, 8'h02);
    check(16'(outs), 16'h0080);
    host.write_byte(8'h35, 8'h80);
    check(16'(outs), 16'h01f0);
    vbus_ok = 1'b0;
    settle();
    check(16'(outs), 16'h0170);
    vbus_ok = 1'b1;
    settle();
    check(16'(outs), 16'h01f0);
    host.write_byte(8'h34, 8'h00);
    check(16'(outs), 16'h01d0);
    host.write_byte(8'h35, 8'h00);
    check(16'(outs), 16'h0080);
  endtask

  // a write while the clock enable is low must leave no trace
  task automatic clock_freeze();
    ce = 1'b0;
    host.write_byte(8'h35, 8'h80);
    check(16'(outs), 16'h0080);
    ce = 1'b1;
    rd_chk(8'h35, 8'h00);
  endtask

  task automatic reverse_supply();
    host.write_byte(8'h35, 8'h10);
    settle();
    check(16'(outs), 16'h0080);
    reverse_pin = 1'b1;
    settle();
    check(16'(outs), 16'h0088);
    host.write_byte(8'h35, 8'h00);
    check(16'(outs), 16'h0080);
    reverse_pin = 1'b0;
    settle();
  endtask

  task automatic remeasure();
    host.write_byte(8'h35, 8'h20);
    check(16'(outs), 16'h0090);
    host.write_byte(8'h35, 8'h20);
    host.write_byte(8'h35, 8'h00);
    rd_chk(8'h35, 8'h20);
    check(16'(outs), 16'h0090);
    @(posedge mclk);
    #1;
    measure_done = 1'b1;
    @(posedge mclk);
    #1;
    measure_done = 1'b0;
    check(16'(outs), 16'h0080);
    rd_chk(8'h35, 8'h00);
  endtask

  task automatic restore();
    logic [7:0] d;
    host.write_byte(8'h35, 8'h18);
    host.write_byte(8'h37, 8'h00);
    host.write_byte(8'h35, 8'h58);
    check(16'(outs), 16'h0085);
    // write inside the busy window must be dropped
    host.write_byte(8'h34, 8'h03);
    host.read_byte(8'h35, d);
    check(16'(d & 8'h40), 16'h0040);
    repeat (RLEN) @(posedge mclk);
    #1;
    check(16'(outs), 16'h0080);
    check(alert_option, 16'h4a54);
    rd_chk(8'h35, 8'h00);
    rd_chk(8'h34, 8'h00);
  endtask

  initial begin
    err_count       = 0;
    samples_checked = 0;
    resetn          = 1'b0;
    ce              = 1'b1;
    reverse_pin     = 1'b0;
    vbus_ok         = 1'b1;
    measure_done    = 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    resetn = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    reset_values();
    mode_fields();
    alert_fields();
    hiz_mode();
    clock_freeze();
    reverse_supply();
    remeasure();
    restore();
    results();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    $display("MISMATCH t=%0t run did not finish", $time);
    results();
  end
endmodule // cmoc_top_tb
